/* rtl/mbxps_top.sv */
/*
 * modbus slave request checker with port status flags and an
 * axi4-lite register slave.
 * assumes a synchronous environment on ref_clk; port event inputs are
 * one-cycle pulses or levels from the port logic, mode switch is a level.
 */
`timescale 1ns/1ps
`include "mbxps_map.svh"

// Overview of operation
// - an unserviceable request gets an exception reply instead of a normal one
// - unimplemented function code answers exception 01
// - address beyond the valid data map answers exception 02
// - item count zero or above the maximum answers exception 03
// - write single coil accepts only FF00h or 0000h, else exception 03
// - invalid mode change or engaged password lock answers exception 03
// - selector at stop refuses a run request with exception 04
// - selector at run refuses firmware update request with exception 04
// - each serial port has its own ready bit
// - serial error bit set on parity, framing, timeout, crc, exception
// - ethernet port has a ready bit and a communication error bit
// - client limit bit while three clients are connected
// - address obtained bit once the ethernet port has an ip address
// - link bit while the ethernet port is connected
// - speed bit while the ethernet port runs at 100Mbps
module mbxps_top
    import mbxps_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // controller state
    input wire logic mode_switch_run,
    input wire logic password_locked,
    // serial port b events
    input wire logic serial_b_idle,
    input wire mbxps_serr_t serial_b_err_ev,
    // serial port c events
    input wire logic serial_c_idle,
    input wire mbxps_serr_t serial_c_err_ev,
    // ethernet port state
    input wire logic eth_idle,
    input wire logic eth_err_ev,
    input wire logic [1:0] eth_client_count,
    input wire logic eth_ip_valid,
    input wire logic eth_link_up,
    input wire logic eth_speed_100,
    // flags and interrupt
    output logic serial_b_error_relay,
    output logic serial_c_error_relay,
    output logic irq
);

    // ============================================================
    // state
    mbxps_state_t state_q;
    logic [31:0] req0_q; // [7:0] function, [31:16] start address
    logic [31:0] req1_q; // [15:0] count or value, [23:16] mode code
    logic [7:0] res_func_q;
    logic [7:0] res_code_q;
    logic res_exc_q;
    logic [15:0] lim_bits_q;
    logic [15:0] lim_regs_q;
    logic [15:0] addr_top_q;
    logic [9:0] pstat_q;
    logic [4:0] istat_q;
    logic [4:0] imask_q;
    logic [4:0] ev_set;
    logic start_w;
    logic aw_hold_q, w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic [7:0] ex_d;

    // byte-lane merge used by the req0, req1, imask and limits registers
    function automatic logic [31:0] mbxps_merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ============================================================
    // axi4-lite write channel: address and data taken in either order
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'b00; // unmapped writes are dropped with okay

    // ============================================================
    // software registers; writing ctrl bit 0 starts a check
    assign start_w = wr_fire && awaddr_q == `MBXPS_OFF_CTRL && wstrb_q[0]
        && wdata_q[0] && state_q == MBXPS_IDLE;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            req0_q <= 32'h00000000;
            req1_q <= 32'h00000000;
            imask_q <= 5'h00;
            lim_bits_q <= `MBXPS_RST_LIMIT_BITS;
            lim_regs_q <= `MBXPS_RST_LIMIT_REGS;
            addr_top_q <= `MBXPS_RST_ADDR_TOP;
        end else if (wr_fire) begin
            unique case (awaddr_q)
                `MBXPS_OFF_REQ0: req0_q <= mbxps_merge(req0_q, wdata_q,
                    wstrb_q);
                `MBXPS_OFF_REQ1: req1_q <= mbxps_merge(req1_q, wdata_q,
                    wstrb_q);
                `MBXPS_OFF_IMASK: imask_q <= 5'(mbxps_merge({27'h0,
                    imask_q}, wdata_q, wstrb_q));
                `MBXPS_OFF_LIMITS: begin
                    lim_bits_q <= 16'(mbxps_merge({16'h0, lim_bits_q},
                        wdata_q, wstrb_q));
                    lim_regs_q <= 16'(mbxps_merge({16'h0, lim_regs_q},
                        {16'h0, wdata_q[31:16]}, {2'b00, wstrb_q[3:2]}));
                end
                default: ;
            endcase
        end
    end

    // ============================================================
    // request classification; precedence 01, 02, 03, 04
    logic [7:0] fc;
    logic [15:0] st_addr, cnt;
    logic [7:0] mode_req;
    logic [16:0] end_addr;
    assign fc = req0_q[7:0];
    assign st_addr = req0_q[31:16];
    assign cnt = req1_q[15:0];
    assign mode_req = req1_q[23:16];
    assign end_addr = {1'b0, st_addr} + {1'b0, cnt} - 17'h00001;

    always_comb begin
        ex_d = `MBXPS_EX_NONE;
        unique case (fc)
            `MBXPS_FC_RD_COILS, `MBXPS_FC_RD_INPUTS, `MBXPS_FC_WR_COILS,
            `MBXPS_FC_RD_HOLD, `MBXPS_FC_RD_INREG, `MBXPS_FC_WR_REGS: begin
                if (cnt != 16'h0000 && end_addr > {1'b0, addr_top_q}) begin
                    ex_d = `MBXPS_EX_ADDR;
                end else if (cnt == 16'h0000 || cnt > ((fc ==
                    `MBXPS_FC_RD_COILS || fc == `MBXPS_FC_RD_INPUTS ||
                    fc == `MBXPS_FC_WR_COILS) ? lim_bits_q : lim_regs_q))
                begin
                    ex_d = `MBXPS_EX_VALUE;
                end
            end
            `MBXPS_FC_WR_COIL: begin
                if (st_addr > addr_top_q) begin
                    ex_d = `MBXPS_EX_ADDR;
                end else if (cnt != `MBXPS_COIL_ON &&
                    cnt != `MBXPS_COIL_OFF) begin
                    ex_d = `MBXPS_EX_VALUE;
                end
            end
            `MBXPS_FC_WR_REG: begin
                if (st_addr > addr_top_q) begin
                    ex_d = `MBXPS_EX_ADDR;
                end
            end
            `MBXPS_FC_MODE: begin
                // lock and bad codes come before the switch check
                if (password_locked || mode_req > `MBXPS_MODE_FWUPD) begin
                    ex_d = `MBXPS_EX_VALUE;
                end else if (!mode_switch_run &&
                    mode_req == `MBXPS_MODE_RUN) begin
                    ex_d = `MBXPS_EX_FAIL;
                end else if (mode_switch_run &&
                    mode_req == `MBXPS_MODE_FWUPD) begin
                    ex_d = `MBXPS_EX_FAIL;
                end
            end
            default: ex_d = `MBXPS_EX_FUNC;
        endcase
    end

    // ============================================================
    // check sequencer: one request at a time, result held until next
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= MBXPS_IDLE;
            res_func_q <= 8'h00;
            res_code_q <= 8'h00;
            res_exc_q <= 1'b0;
        end else begin
            unique case (state_q)
                MBXPS_IDLE: if (start_w) state_q <= MBXPS_CHECK;
                MBXPS_CHECK: begin
                    state_q <= MBXPS_DONE;
                    res_exc_q <= ex_d != `MBXPS_EX_NONE;
                    res_func_q <= (ex_d != `MBXPS_EX_NONE) ?
                        (fc | `MBXPS_EX_FLAG) : fc;
                    res_code_q <= ex_d;
                end
                MBXPS_DONE: state_q <= MBXPS_IDLE;
                default: state_q <= MBXPS_IDLE;
            endcase
        end
    end

    // ============================================================
    // port status flags
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pstat_q <= 10'h000;
        end else begin
            pstat_q[`MBXPS_PS_B_READY] <= serial_b_idle;
            pstat_q[`MBXPS_PS_C_READY] <= serial_c_idle;
            pstat_q[`MBXPS_PS_E_READY] <= eth_idle;
            // error flags are sticky; a written one clears, an event wins
            if (|serial_b_err_ev) begin
                pstat_q[`MBXPS_PS_B_ERR] <= 1'b1;
            end else if (wr_fire && awaddr_q == `MBXPS_OFF_PSTAT &&
                wstrb_q[0] && wdata_q[`MBXPS_PS_B_ERR]) begin
                pstat_q[`MBXPS_PS_B_ERR] <= 1'b0;
            end
            if (|serial_c_err_ev) begin
                pstat_q[`MBXPS_PS_C_ERR] <= 1'b1;
            end else if (wr_fire && awaddr_q == `MBXPS_OFF_PSTAT &&
                wstrb_q[0] && wdata_q[`MBXPS_PS_C_ERR]) begin
                pstat_q[`MBXPS_PS_C_ERR] <= 1'b0;
            end
            if (eth_err_ev) begin
                pstat_q[`MBXPS_PS_E_ERR] <= 1'b1;
            end else if (wr_fire && awaddr_q == `MBXPS_OFF_PSTAT &&
                wstrb_q[0] && wdata_q[`MBXPS_PS_E_ERR]) begin
                pstat_q[`MBXPS_PS_E_ERR] <= 1'b0;
            end
            pstat_q[`MBXPS_PS_E_CLIM] <=
                eth_client_count == `MBXPS_CLIENT_MAX;
            pstat_q[`MBXPS_PS_E_ADDR] <= eth_ip_valid;
            pstat_q[`MBXPS_PS_E_LINK] <= eth_link_up;
            pstat_q[`MBXPS_PS_E_FAST] <= eth_speed_100;
        end
    end
    assign serial_b_error_relay = pstat_q[`MBXPS_PS_B_ERR];
    assign serial_c_error_relay = pstat_q[`MBXPS_PS_C_ERR];

    // ============================================================
    // sticky interrupt status, write one to clear, set wins
    assign ev_set = {eth_err_ev, |serial_c_err_ev, |serial_b_err_ev,
        state_q == MBXPS_CHECK && ex_d != `MBXPS_EX_NONE,
        state_q == MBXPS_CHECK};

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            istat_q <= 5'h00;
        end else if (wr_fire && awaddr_q == `MBXPS_OFF_ISTAT &&
            wstrb_q[0]) begin
            istat_q <= (istat_q & ~wdata_q[4:0]) | ev_set;
        end else begin
            istat_q <= istat_q | ev_set;
        end
    end
    assign irq = |(istat_q & imask_q);

    // ============================================================
    // axi4-lite read channel, one cycle after the address
    logic [31:0] rd_mux;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (s_axi_araddr)
            `MBXPS_OFF_CTRL: rd_mux = {30'h0, state_q != MBXPS_IDLE,
                1'b0};
            `MBXPS_OFF_REQ0: rd_mux = req0_q;
            `MBXPS_OFF_REQ1: rd_mux = req1_q;
            `MBXPS_OFF_RESULT: rd_mux = {15'h0, res_exc_q, res_code_q,
                res_func_q};
            `MBXPS_OFF_PSTAT: rd_mux = {22'h0, pstat_q};
            `MBXPS_OFF_ISTAT: rd_mux = {27'h0, istat_q};
            `MBXPS_OFF_IMASK: rd_mux = {27'h0, imask_q};
            `MBXPS_OFF_LIMITS: rd_mux = {lim_regs_q, lim_bits_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_rresp = 2'b00;

    // the master side by polling the ready bits above

endmodule

/* rtl/mbxps_map.svh */
/*
 * register offsets, field positions, reset values and codes of the
 * request checker and port status block.
 * assumes inclusion by bare name from the package and the design.
 */
`ifndef MBXPS_MAP_SVH
`define MBXPS_MAP_SVH

// ============================================================
// register byte offsets
`define MBXPS_OFF_CTRL 8'h00
`define MBXPS_OFF_REQ0 8'h04
`define MBXPS_OFF_REQ1 8'h08
`define MBXPS_OFF_RESULT 8'h0C
`define MBXPS_OFF_PSTAT 8'h10
`define MBXPS_OFF_ISTAT 8'h14
`define MBXPS_OFF_IMASK 8'h18
`define MBXPS_OFF_LIMITS 8'h1C

// ============================================================
// exception codes
`define MBXPS_EX_NONE 8'h00
`define MBXPS_EX_FUNC 8'h01
`define MBXPS_EX_ADDR 8'h02
`define MBXPS_EX_VALUE 8'h03
`define MBXPS_EX_FAIL 8'h04

// ============================================================
// function codes and coil values
`define MBXPS_FC_RD_COILS 8'h01
`define MBXPS_FC_RD_INPUTS 8'h02
`define MBXPS_FC_RD_HOLD 8'h03
`define MBXPS_FC_RD_INREG 8'h04
`define MBXPS_FC_WR_COIL 8'h05
`define MBXPS_FC_WR_REG 8'h06
`define MBXPS_FC_WR_COILS 8'h0F
`define MBXPS_FC_WR_REGS 8'h10
`define MBXPS_FC_MODE 8'h41
`define MBXPS_COIL_ON 16'hFF00
`define MBXPS_COIL_OFF 16'h0000
`define MBXPS_EX_FLAG 8'h80

// ============================================================
// mode request codes
`define MBXPS_MODE_STOP 8'h00
`define MBXPS_MODE_RUN 8'h01
`define MBXPS_MODE_FWUPD 8'h02

// ============================================================
// reset values and client limit
`define MBXPS_RST_LIMIT_BITS 16'h07D0
`define MBXPS_RST_LIMIT_REGS 16'h007D
`define MBXPS_RST_ADDR_TOP 16'hFFFF
`define MBXPS_CLIENT_MAX 2'h3

// ============================================================
// port status and event bit positions
`define MBXPS_PS_B_READY 0
`define MBXPS_PS_B_ERR 1
`define MBXPS_PS_C_READY 2
`define MBXPS_PS_C_ERR 3
`define MBXPS_PS_E_READY 4
`define MBXPS_PS_E_ERR 5
`define MBXPS_PS_E_CLIM 6
`define MBXPS_PS_E_ADDR 7
`define MBXPS_PS_E_LINK 8
`define MBXPS_PS_E_FAST 9
`define MBXPS_IS_DONE 0
`define MBXPS_IS_EXC 1
`define MBXPS_IS_B_ERR 2
`define MBXPS_IS_C_ERR 3
`define MBXPS_IS_E_ERR 4

`endif

/* rtl/mbxps_pkg.sv */
/*
 * types of the request checker and port status block.
 * assumes the map header sits beside it on the include path.
 */
package mbxps_pkg;
`include "mbxps_map.svh"

    // states of the check sequencer
    typedef enum logic [1:0] {
        MBXPS_IDLE = 2'b00,
        MBXPS_CHECK = 2'b01,
        MBXPS_DONE = 2'b10
    } mbxps_state_t;

    // serial port error causes
    typedef struct packed {
        logic parity;
        logic framing;
        logic timeout;
        logic crc;
        logic exc_rx;
    } mbxps_serr_t;
endpackage

/* tb/mbxps_top_asserts.sv */
/*
 * concurrent checks on the request checker's bus and relay outputs.
 * assumes binding onto mbxps_top, one clock domain on ref_clk.
 */
`timescale 1ns/1ps
module mbxps_top_asserts
    import mbxps_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // serial port events and relays
    input wire mbxps_serr_t serial_b_err_ev,
    input wire mbxps_serr_t serial_c_err_ev,
    input wire logic serial_b_error_relay,
    input wire logic serial_c_error_relay
);
    // ============================================================
    // relays
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    chk_b_relay_set: assert property (
        serial_b_err_ev != 5'h0 |=> serial_b_error_relay)
        else $error("b relay missed event");
    chk_c_relay_set: assert property (
        serial_c_err_ev != 5'h0 |=> serial_c_error_relay)
        else $error("c relay missed event");
    chk_b_relay_cause: assert property (
        $rose(serial_b_error_relay) |-> $past(serial_b_err_ev) != 5'h0)
        else $error("b relay rose alone");
    chk_c_relay_cause: assert property (
        $rose(serial_c_error_relay) |-> $past(serial_c_err_ev) != 5'h0)
        else $error("c relay rose alone");
    // only a register write may clear the b relay
    chk_relay_sticky: assert property (
        serial_b_error_relay && !s_axi_wvalid && !$past(s_axi_wvalid)
        && !$past(s_axi_wvalid, 2) |=> serial_b_error_relay)
        else $error("b relay cleared alone");

    // ============================================================
    // bus
    chk_bresp_okay: assert property (
        s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    chk_rresp_okay: assert property (
        s_axi_rvalid |-> s_axi_rresp == 2'h0)
        else $error("read response not okay");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_read_blocked: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken early");
    chk_write_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
endmodule

/* tb/mbxps_port_model.sv */
/*
 * far side port logic: runs serial transactions and reports faults.
 * assumes start and fault come from the bench on ref_clk edges.
 */
`timescale 1ns/1ps
module mbxps_port_model
    import mbxps_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // transaction requests
    input wire logic start_b,
    input wire logic start_c,
    input wire logic [4:0] fault,
    // port state towards the block
    output logic serial_b_idle,
    output logic serial_c_idle,
    output mbxps_serr_t serial_b_err_ev,
    output mbxps_serr_t serial_c_err_ev
);
    // ============================================================
    // transaction sequencing
    logic [3:0] cnt_q [2];
    logic [4:0] ev_q [2];
    logic [1:0] start;
    assign start = {start_c, start_b};

    // a start while busy is dropped, so only one runs per port
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '{default: '0};
            ev_q <= '{default: '0};
        end else begin
            for (int i = 0; i < 2; i++) begin
                ev_q[i] <= 5'h0;
                if (cnt_q[i] != 4'h0) begin
                    cnt_q[i] <= cnt_q[i] - 4'h1;
                    if (cnt_q[i] == 4'h1)
                        ev_q[i] <= fault; // fault shows at the close
                end else if (start[i]) begin
                    cnt_q[i] <= 4'hC;
                end
            end
        end
    end

    // ready while no transaction runs
    assign serial_b_idle = (cnt_q[0] == 4'h0);
    assign serial_c_idle = (cnt_q[1] == 4'h0);
    assign serial_b_err_ev = mbxps_serr_t'(ev_q[0]);
    assign serial_c_err_ev = mbxps_serr_t'(ev_q[1]);
endmodule

/* tb/test_mbxps_top.sv */
/*
 * self-checking bench: request table, port status and interrupt.
 * assumes the port model and checker compiled before this file.
 */
`timescale 1ns/1ps
`include "mbxps_map.svh"
module test_mbxps_top
    import mbxps_pkg::*;
;
    // ============================================================
    // signals
    logic ref_clk, nrst, p;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, eth_client_count;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, mode_switch_run, password_locked;
    logic serial_b_idle, serial_c_idle, eth_idle, eth_err_ev, irq;
    logic eth_ip_valid, eth_link_up, eth_speed_100, start_b, start_c;
    logic serial_b_error_relay, serial_c_error_relay;
    logic [4:0] fault;
    mbxps_serr_t serial_b_err_ev, serial_c_err_ev;
    int err_total, samples_checked;
    logic [63:0] e;
    // func, start address, count or value and mode, lock and run, code
    logic [63:0] cases [17] = '{
        64'h07_0000_000001_00_01,
        64'h04_0000_00007D_00_00,
        64'h0F_FFFF_000002_00_02,
        64'h02_0000_000000_00_03,
        64'h03_0000_00007E_00_03,
        64'h01_0000_0007D1_00_03,
        64'h05_0000_00FF00_00_00,
        64'h05_0000_000000_00_00,
        64'h05_0000_001234_00_03,
        64'h06_FFFF_000001_00_00,
        64'h41_0000_000000_00_00,
        64'h41_0000_030000_01_03,
        64'h41_0000_010000_03_03,
        64'h41_0000_010000_00_04,
        64'h41_0000_020000_01_04,
        64'h41_0000_010000_01_00,
        64'h10_FFFF_000001_00_00
    };

    mbxps_top dut (.*);
    mbxps_port_model u_ports (.ref_clk, .nrst, .start_b, .start_c,
        .fault, .serial_b_idle, .serial_c_idle, .serial_b_err_ev,
        .serial_c_err_ev);

    // ============================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        v = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask

    // one transaction on port b (q low) or c (q high)
    task automatic run_port(input logic q, input logic [4:0] f);
        fault <= f;
        start_b <= !q;
        start_c <= q;
        @(posedge ref_clk);
        start_b <= 1'h0;
        start_c <= 1'h0;
        repeat (2) @(posedge ref_clk);
    endtask

    function automatic logic [31:0] exp_result(input logic [7:0] f,
        input logic [7:0] c);
        if (c == 8'h00)
            return {24'h0, f};
        return {15'h0, 1'h1, c, f | `MBXPS_EX_FLAG};
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ============================================================
    // clock, watchdog and tests
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        $display("ERROR at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
            s_axi_rready, start_b, start_c, mode_switch_run, eth_err_ev,
            password_locked, eth_idle, eth_ip_valid, eth_link_up,
            eth_speed_100, s_axi_awaddr, s_axi_araddr, s_axi_wstrb,
            s_axi_wdata, fault, eth_client_count, err_total,
            samples_checked, nrst} = '0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'h1;
        // reset values and unmapped space
        axi_rd(`MBXPS_OFF_LIMITS, d);
        chk(d, 32'h007D07D0);
        axi_rd(`MBXPS_OFF_ISTAT, d);
        chk(d, 32'h0);
        axi_wr(8'h24, 32'hFFFFFFFF);
        axi_rd(8'h24, d);
        chk(d, 32'h0);
        // request table with the exception interrupt unmasked
        axi_wr(`MBXPS_OFF_IMASK, 32'h2);
        for (int i = 0; i < 17; i++) begin
            e = cases[i];
            mode_switch_run <= e[8];
            password_locked <= e[9];
            axi_wr(`MBXPS_OFF_REQ0, {e[55:40], 8'h00, e[63:56]});
            axi_wr(`MBXPS_OFF_REQ1, {8'h00, e[39:16]});
            axi_wr(`MBXPS_OFF_CTRL, 32'h1);
            do axi_rd(`MBXPS_OFF_ISTAT, d); while (d[0] !== 1'h1);
            axi_rd(`MBXPS_OFF_RESULT, d);
            chk(d, exp_result(e[63:56], e[7:0]));
            chk(32'(irq), 32'(e[7:0] != 8'h00));
            axi_wr(`MBXPS_OFF_ISTAT, 32'h3);
            chk(32'(irq), 32'h0);
        end
        // every fault kind on port b (masked), one on port c (unmasked)
        axi_wr(`MBXPS_OFF_IMASK, 32'hA);
        for (int k = 0; k < 6; k++) begin
            p = (k == 5);
            run_port(p, p ? 5'h02 : 5'h10 >> k);
            if (k == 0) begin
                axi_rd(`MBXPS_OFF_PSTAT, d);
                chk({28'h0, d[3:0]}, 32'h4);
            end
            while (!(serial_b_idle && serial_c_idle)) @(posedge ref_clk);
            repeat (2) @(posedge ref_clk);
            chk({31'h0, p ? serial_c_error_relay : serial_b_error_relay},
                32'h1);
            chk(32'(irq), 32'(p));
            axi_rd(`MBXPS_OFF_ISTAT, d);
            chk(d, 32'h4 << p);
            axi_wr(`MBXPS_OFF_PSTAT, 32'h2 << (2 * p));
            axi_wr(`MBXPS_OFF_ISTAT, 32'h4 << p);
            chk({30'h0, serial_c_error_relay, serial_b_error_relay},
                32'h0);
        end
        // ethernet flags, two opposite settings
        {eth_idle, eth_ip_valid, eth_link_up, eth_speed_100} <= 4'hD;
        eth_client_count <= 2'h3;
        eth_err_ev <= 1'h1;
        @(posedge ref_clk);
        eth_err_ev <= 1'h0;
        repeat (2) @(posedge ref_clk);
        axi_rd(`MBXPS_OFF_PSTAT, d);
        chk(d, 32'h2F5);
        axi_rd(`MBXPS_OFF_ISTAT, d);
        chk(d, 32'h10);
        {eth_idle, eth_ip_valid, eth_link_up, eth_speed_100} <= 4'h2;
        eth_client_count <= 2'h2;
        axi_wr(`MBXPS_OFF_PSTAT, 32'h20);
        axi_wr(`MBXPS_OFF_ISTAT, 32'h10);
        axi_rd(`MBXPS_OFF_PSTAT, d);
        chk(d, 32'h105);
        end_of_test();
    end
endmodule

bind mbxps_top mbxps_top_asserts u_chk (.*);
